// ==== logic/host_port_pkg.sv ====
package host_port_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 18;
  localparam int MEM_WORDS = 1024;
  localparam int MEM_IDX_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] REG_MEM_ADDR_LO = 16'h0022;
  localparam logic [15:0] REG_MEM_ADDR_HI = 16'h0024;
  localparam logic [15:0] REG_INCR_CTRL = 16'h0026;
  localparam logic [15:0] REG_MEM_PORT = 16'h0028;
  localparam logic [15:0] REG_BLT_PORT = 16'h002a;
  localparam logic [2:0] STRAP_VARIANT3 = 3'b011;
  localparam int STRAP_SEL_BIT = 2;
  localparam logic [1:0] INC_BYTE_HI_WORD = 2'b00;
  localparam logic [1:0] INC_WORD_ONLY = 2'b01;
  localparam logic [1:0] INC_NONE = 2'b10;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h00002;
  localparam logic [15:0] REG_NUM_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [1:0] INCR_RST = 2'b00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [2:0] STRAP_RST = 3'b111;

  typedef enum logic [1:0]
  {
    OP_CMD_WR = 2'b00,
    OP_DATA_WR = 2'b01,
    OP_DATA_RD = 2'b10
  } host_op_t;

  typedef enum logic [1:0]
  {
    H_IDLE = 2'b00,
    H_ISSUE = 2'b01,
    H_WAIT = 2'b10
  } host_state_t;
endpackage

// ==== logic/host_port_if.sv ====
`timescale 1ns/1ps
interface host_port_if;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic byte_acc;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic busy;

  modport dev
  (
    input cmd_wr, data_wr, data_rd, byte_acc, wdata,
    output rdata, rvalid, busy
  );

  modport host
  (
    output cmd_wr, data_wr, data_rd, byte_acc, wdata,
    input rdata, rvalid, busy
  );
endinterface

// ==== logic/sync_fifo.sv ====
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,              // clock
  input wire logic arst_n_i,            // async reset, low
  input wire logic in_valid_i,          // push request
  input wire logic [WIDTH-1:0] in_data_i, // push data
  output logic in_ready_o,              // room for a word
  output logic full_o,                  // no room
  output logic out_valid_o,             // word available
  output logic [WIDTH-1:0] out_data_o,  // head word
  input wire logic out_ready_i          // pop request
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [PW:0] count_ff, nxt_count;
  logic rdy_ff, full_ff, valid_ff;
  logic push, pop;

  always_comb
  begin
    push = in_valid_i & rdy_ff;
    pop = out_ready_i & valid_ff;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      rdy_ff <= 1'b1;
      full_ff <= 1'b0;
      valid_ff <= 1'b0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      rdy_ff <= nxt_count != (PW+1)'(DEPTH);
      full_ff <= nxt_count == (PW+1)'(DEPTH);
      valid_ff <= nxt_count != '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data_i;
  end

  assign in_ready_o = rdy_ff;
  assign full_o = full_ff;
  assign out_valid_o = valid_ff;
  assign out_data_o = mem[rd_ptr_ff];
endmodule

// ==== logic/indirect_port_dev.sv ====
`timescale 1ns/1ps
module indirect_port_dev
  import host_port_pkg::*;
(
  input wire logic mclk_i,                  // system clock
  input wire logic arst_n_i,                // async reset, low
  input wire logic [2:0] host_select_strap_i, // host variant strap
  host_port_if.dev link,                    // indirect host bus
  output logic indirect_active_o,           // indirect port selected
  output logic [2:0] variant_o,             // captured strap value
  output logic burst_mode_o,                // memory burst active
  output logic blt_valid_o,                 // block data available
  output logic [15:0] blt_data_o,           // block data word
  input wire logic blt_ready_i              // block data taken
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic strap_done_ff, nxt_strap_done;
  logic [2:0] strap_ff, nxt_strap;
  logic [15:0] reg_num_ff, nxt_reg_num;
  logic mem_mode_ff, nxt_mem_mode;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [1:0] incr_ff, nxt_incr;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [15:0] mem [MEM_WORDS];
  logic active_ff, nxt_active;
  logic active;
  logic cmd, wr, rd;
  logic mem_we_lo, mem_we_hi;
  logic [MEM_IDX_W-1:0] mem_idx;
  logic [15:0] mem_word;
  logic blt_push, fifo_rdy, fifo_full;

  // next address after a memory cycle
  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] mode,
    input logic byte_acc
  );
    logic hi_lane;
    hi_lane = a[0];
    case (mode)
      INC_BYTE_HI_WORD:
        step_addr = (byte_acc && !hi_lane) ? a : a + ADDR_STEP;
      INC_WORD_ONLY:
        step_addr = byte_acc ? a : a + ADDR_STEP;
      default:
        step_addr = a;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_strap_done = 1'b1;
    nxt_strap = strap_done_ff ? strap_ff : host_select_strap_i;
    nxt_active = active_ff;
    if (!strap_done_ff)
      nxt_active = !host_select_strap_i[STRAP_SEL_BIT];
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap_done_ff <= 1'b0;
      strap_ff <= STRAP_RST;
      active_ff <= 1'b0;
    end
    else
    begin
      strap_done_ff <= nxt_strap_done;
      strap_ff <= nxt_strap;
      active_ff <= nxt_active;
    end
  end

  // variants 000..011 all use this port; 011 is the strobed one
  assign active = active_ff;

  // ----------------------------------------------------------------
  // command and data cycles
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd = active & link.cmd_wr;
    wr = active & link.data_wr & ~link.cmd_wr;
    rd = active & link.data_rd & ~link.cmd_wr & ~link.data_wr;
    nxt_reg_num = reg_num_ff;
    nxt_mem_mode = mem_mode_ff;
    nxt_addr = addr_ff;
    nxt_incr = incr_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    mem_we_lo = 1'b0;
    mem_we_hi = 1'b0;
    blt_push = 1'b0;
    mem_idx = addr_ff[MEM_IDX_W:1];
    mem_word = mem[mem_idx];
    if (cmd)
    begin
      nxt_reg_num = link.wdata;
      nxt_mem_mode = link.wdata == REG_MEM_PORT;
    end
    else if (wr && mem_mode_ff)
    begin
      // lane follows address parity on byte cycles
      mem_we_lo = !link.byte_acc || !addr_ff[0];
      mem_we_hi = !link.byte_acc || addr_ff[0];
      nxt_addr = step_addr(addr_ff, incr_ff, link.byte_acc);
    end
    else if (wr)
    begin
      case (reg_num_ff)
        REG_MEM_ADDR_LO: nxt_addr[15:0] = link.wdata;
        REG_MEM_ADDR_HI: nxt_addr[17:16] = link.wdata[1:0];
        REG_INCR_CTRL: nxt_incr = link.wdata[1:0];
        REG_BLT_PORT: blt_push = 1'b1;
        default: nxt_incr = incr_ff;
      endcase
    end
    else if (rd && mem_mode_ff)
    begin
      nxt_rvalid = 1'b1;
      if (!link.byte_acc)
        nxt_rdata = mem_word;
      else if (addr_ff[0])
        nxt_rdata = {mem_word[15:8], 8'h00};
      else
        nxt_rdata = {8'h00, mem_word[7:0]};
      nxt_addr = step_addr(addr_ff, incr_ff, link.byte_acc);
    end
    else if (rd)
    begin
      nxt_rvalid = 1'b1;
      case (reg_num_ff)
        REG_MEM_ADDR_LO: nxt_rdata = addr_ff[15:0];
        REG_MEM_ADDR_HI: nxt_rdata = {14'h0000, addr_ff[17:16]};
        REG_INCR_CTRL: nxt_rdata = {14'h0000, incr_ff};
        default: nxt_rdata = DATA_RST;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_num_ff <= REG_NUM_RST;
      mem_mode_ff <= 1'b0;
      addr_ff <= ADDR_RST;
      incr_ff <= INCR_RST;
      rdata_ff <= DATA_RST;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_num_ff <= nxt_reg_num;
      mem_mode_ff <= nxt_mem_mode;
      addr_ff <= nxt_addr;
      incr_ff <= nxt_incr;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // internal memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (mem_we_lo)
      mem[mem_idx][7:0] <= link.wdata[7:0];
    if (mem_we_hi)
      mem[mem_idx][15:8] <= link.wdata[15:8];
  end

  // ----------------------------------------------------------------
  // block-transfer data buffer
  // ----------------------------------------------------------------
  sync_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_blt_fifo (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(blt_push),
    .in_data_i(link.wdata),
    .in_ready_o(fifo_rdy),
    .full_o(fifo_full),
    .out_valid_o(blt_valid_o),
    .out_data_o(blt_data_o),
    .out_ready_i(blt_ready_i)
  );

  assign link.rdata = rdata_ff;
  assign link.rvalid = rvalid_ff;
  assign link.busy = fifo_full;
  assign indirect_active_o = active_ff;
  assign variant_o = strap_ff;
  assign burst_mode_o = mem_mode_ff;
endmodule

// ==== logic/indirect_port_host.sv ====
`timescale 1ns/1ps
module indirect_port_host
  import host_port_pkg::*;
(
  input wire logic mclk_i,            // system clock
  input wire logic arst_n_i,          // async reset, low
  host_port_if.host link,             // indirect host bus
  input wire logic req_valid_i,       // user request
  input wire host_op_t req_op_i,      // command, write or read
  input wire logic [15:0] req_data_i, // register number or data
  input wire logic req_byte_i,        // byte cycle wanted
  output logic req_ready_o,           // request accepted when high
  output logic rsp_valid_o,           // read data pulse
  output logic [15:0] rsp_data_o,     // read data
  output logic mem_mode_o             // memory cycles enabled
);
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  host_state_t state_ff, nxt_state;
  host_op_t op_ff, nxt_op;
  logic [15:0] data_ff, nxt_data;
  logic byte_ff, nxt_byte;
  logic cmd_ff, nxt_cmd, wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic cyc_byte_ff, nxt_cyc_byte;
  logic ready_ff, nxt_ready, rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_data_ff, nxt_rsp_data;
  logic mem_mode_ff, nxt_mem_mode;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_data = data_ff;
    nxt_byte = byte_ff;
    nxt_cmd = 1'b0;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_cyc_byte = cyc_byte_ff;
    nxt_ready = ready_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_mem_mode = mem_mode_ff;
    case (state_ff)
      H_IDLE:
        if (req_valid_i && ready_ff)
        begin
          nxt_op = req_op_i;
          nxt_data = req_data_i;
          nxt_byte = req_byte_i;
          nxt_ready = 1'b0;
          nxt_state = H_ISSUE;
        end
      H_ISSUE:
        if (!link.busy)
        begin
          // one cycle per request, exactly as asked
          nxt_cmd = op_ff == OP_CMD_WR;
          nxt_wr = op_ff == OP_DATA_WR;
          nxt_rd = op_ff == OP_DATA_RD;
          // byte cycles only once memory access is open
          nxt_cyc_byte = byte_ff && mem_mode_ff
                         && op_ff != OP_CMD_WR;
          if (op_ff == OP_CMD_WR)
            nxt_mem_mode = data_ff == REG_MEM_PORT;
          if (op_ff == OP_DATA_RD)
            nxt_state = H_WAIT;
          else
          begin
            nxt_state = H_IDLE;
            nxt_ready = 1'b1;
          end
        end
      H_WAIT:
        if (link.rvalid)
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = link.rdata;
          nxt_ready = 1'b1;
          nxt_state = H_IDLE;
        end
      default:
      begin
        nxt_state = H_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= H_IDLE;
      op_ff <= OP_CMD_WR;
      data_ff <= DATA_RST;
      byte_ff <= 1'b0;
      cmd_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cyc_byte_ff <= 1'b0;
      ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= DATA_RST;
      mem_mode_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      data_ff <= nxt_data;
      byte_ff <= nxt_byte;
      cmd_ff <= nxt_cmd;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cyc_byte_ff <= nxt_cyc_byte;
      ready_ff <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      mem_mode_ff <= nxt_mem_mode;
    end
  end

  assign link.cmd_wr = cmd_ff;
  assign link.data_wr = wr_ff;
  assign link.data_rd = rd_ff;
  assign link.byte_acc = cyc_byte_ff;
  assign link.wdata = data_ff;
  assign req_ready_o = ready_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;
  assign mem_mode_o = mem_mode_ff;
endmodule

// ==== tb/host_port_asserts.sv ====
`timescale 1ns/1ps
module host_port_asserts
  import host_port_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic arst_n_i, // reset, low
  input wire logic cmd_wr, // command strobe
  input wire logic data_wr, // write strobe
  input wire logic data_rd, // read strobe
  input wire logic byte_acc, // byte cycle
  input wire logic [15:0] wdata, // write data
  input wire logic [15:0] rdata, // read data
  input wire logic rvalid, // read answer
  input wire logic busy // buffer full
);
  logic mem_ff;
  logic nxt_mem;
  always_comb
  begin
    nxt_mem = mem_ff;
    if (cmd_wr)
      nxt_mem = (wdata == REG_MEM_PORT);
  end
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
      mem_ff <= 1'b0;
    else
      mem_ff <= nxt_mem;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rd_answer;
    data_rd |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read strobe got no answer");
  property p_rvalid_cause;
    rvalid |-> $past(data_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read strobe");
  property p_rdata_hold;
    !rvalid |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without answer");
  property p_cmd_word;
    cmd_wr |-> !byte_acc;
  endproperty
  a_cmd_word: assert property (p_cmd_word)
    else $error("byte wide command cycle");
  property p_reg_word;
    (data_wr || data_rd) && !mem_ff |-> !byte_acc;
  endproperty
  a_reg_word: assert property (p_reg_word)
    else $error("byte wide register cycle");
  property p_one_strobe;
    $onehot0({cmd_wr, data_wr, data_rd});
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("several strobes at once");
  property p_strobe_gap;
    cmd_wr |=> !(cmd_wr || data_wr || data_rd);
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("cycle right after command");
  property p_busy_cause;
    $rose(busy) |-> $past(data_wr) || $past(data_wr, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("buffer filled without a write");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import host_port_pkg::*;
;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  host_op_t req_op_i = OP_CMD_WR;
  logic [15:0] req_data_i = 16'h0000;
  logic req_byte_i = 1'b0;
  logic blt_ready_i = 1'b0;
  logic [2:0] host_select_strap_i = STRAP_VARIANT3;
  logic req_ready_o, rsp_valid_o, mem_mode_o, blt_valid_o;
  logic indirect_active_o, burst_mode_o;
  logic [15:0] rsp_data_o, blt_data_o;
  logic [2:0] variant_o;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'h96d6aae6;
  logic [17:0] a;
  logic [1:0] mode;
  logic [7:0] mb [int];
  logic [15:0] q [$];
  host_port_if link ();
  always #12.5 mclk_i = ~mclk_i;
  indirect_port_dev i_indirect_port_dev (.mclk_i, .arst_n_i,
    .host_select_strap_i, .link(link.dev),
    .indirect_active_o, .variant_o, .burst_mode_o, .blt_valid_o,
    .blt_data_o, .blt_ready_i);
  indirect_port_host i_indirect_port_host (.mclk_i, .arst_n_i,
    .link(link.host), .req_valid_i, .req_op_i, .req_data_i, .req_byte_i,
    .req_ready_o, .rsp_valid_o, .rsp_data_o, .mem_mode_o);
  host_port_asserts i_host_port_asserts (.mclk_i, .arst_n_i,
    .cmd_wr(link.cmd_wr), .data_wr(link.data_wr), .data_rd(link.data_rd),
    .byte_acc(link.byte_acc), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid), .busy(link.busy));
  // ----------------------------------------
  // stimulus and model
  // ----------------------------------------
  task automatic chk(input string nm, input logic [17:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic req(input host_op_t op, input logic [15:0] d,
    input logic b);
    int n;
    n = 0;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_data_i <= d;
    req_byte_i <= b;
    do
      @(posedge mclk_i);
    while (req_ready_o !== 1'b1 && ++n < 100);
    req_valid_i <= 1'b0;
    if (n >= 100)
      n_errors++;
  endtask
  task automatic rd(input logic b, output logic [15:0] v);
    int n;
    n = 0;
    req(OP_DATA_RD, 16'h0000, b);
    do
      @(posedge mclk_i);
    while (rsp_valid_o !== 1'b1 && ++n < 20);
    if (n >= 20)
      n_errors++;
    v = rsp_data_o;
  endtask
  task automatic wreg(input logic [15:0] r, d);
    req(OP_CMD_WR, r, 1'b0);
    req(OP_DATA_WR, d, 1'b0);
  endtask
  task automatic creg(input logic [15:0] r, input logic [17:0] e);
    logic [15:0] v;
    req(OP_CMD_WR, r, 1'b0);
    rd(1'b0, v);
    chk("reg", {2'b00, v}, e);
  endtask
  task automatic mop(input logic w, b, input logic [15:0] d);
    logic [15:0] v, e;
    int i;
    i = (a & 18'h007fe);
    if (w)
    begin
      req(OP_DATA_WR, d, b);
      if (!b || !a[0])
        mb[i] = d[7:0];
      if (!b || a[0])
        mb[i | 1] = d[15:8];
    end
    else
    begin
      rd(b, v);
      e = {mb[i | 1], mb[i]};
      if (b)
        e = a[0] ? {e[15:8], 8'h00} : {8'h00, e[7:0]};
      chk("mem", {2'b00, v}, {2'b00, e});
    end
    if ((mode == 2'b00 && (!b || a[0])) || (mode == 2'b01 && !b))
      a = a + 18'h00002;
  endtask
  task automatic t_mem;
    int r;
    for (int m = 0; m < 4; m++)
    begin
      r = $random(seed);
      a = {2'b00, r[15:0] & 16'h07fe};
      mode = 2'b00;
      wreg(REG_INCR_CTRL, 16'h0000);
      wreg(REG_MEM_ADDR_LO, a[15:0]);
      wreg(REG_MEM_ADDR_HI, 16'h0000);
      req(OP_CMD_WR, REG_MEM_PORT, 1'b0);
      repeat (3) @(posedge mclk_i);
      chk("burst", {17'h0, burst_mode_o}, 18'h00001);
      chk("host mode", {17'h0, mem_mode_o}, 18'h00001);
      repeat (16) mop(1'b1, 1'b0, 16'($random(seed)));
      creg(REG_MEM_ADDR_LO, a);
      mode = 2'(m);
      wreg(REG_INCR_CTRL, {14'h0, mode});
      // rewind into the words just written, odd or even start
      a = {2'b00, r[15:0] & 16'h07fe};
      a[0] = r[16];
      wreg(REG_MEM_ADDR_LO, a[15:0]);
      req(OP_CMD_WR, REG_MEM_PORT, 1'b0);
      repeat (12)
      begin
        r = $random(seed);
        mop(r[0], r[1], r[31:16]);
      end
      creg(REG_MEM_ADDR_LO, a);
      $display("test mem mode %0d done", m);
    end
  endtask
  task automatic t_reg;
    logic [15:0] d;
    d = 16'($random(seed));
    req(OP_CMD_WR, REG_MEM_ADDR_LO, 1'b0);
    req(OP_DATA_WR, ~d, 1'b0);
    req(OP_DATA_WR, d, 1'b0);
    creg(REG_MEM_ADDR_LO, {2'b00, d});
    wreg(REG_INCR_CTRL, 16'h0002);
    creg(REG_INCR_CTRL, 18'h00002);
    wreg(REG_MEM_ADDR_HI, 16'h0003);
    creg(REG_MEM_ADDR_HI, 18'h00003);
    creg(REG_BLT_PORT, 18'h00000);
    $display("test reg done");
  endtask
  task automatic t_blt;
    int n;
    n = 0;
    req(OP_CMD_WR, REG_BLT_PORT, 1'b0);
    repeat (FIFO_DEPTH)
    begin
      q.push_back(16'($random(seed)));
      req(OP_DATA_WR, q[$], 1'b0);
    end
    repeat (4) @(posedge mclk_i);
    chk("busy", {17'h0, link.busy}, 18'h00001);
    blt_ready_i <= 1'b1;
    while (q.size() > 0 && n++ < 50)
    begin
      @(posedge mclk_i);
      if (blt_valid_o === 1'b1)
        chk("blt", {2'b00, blt_data_o}, {2'b00, q.pop_front()});
    end
    chk("left", 18'(q.size()), 18'h00000);
    @(posedge mclk_i);
    chk("empty", {17'h0, blt_valid_o}, 18'h00000);
    blt_ready_i <= 1'b0;
    $display("test blt done");
  endtask
  task automatic results;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("variant", {15'h0, variant_o}, {15'h0, STRAP_VARIANT3});
    chk("active", {17'h0, indirect_active_o}, 18'h00001);
    t_reg;
    t_mem;
    t_blt;
    // a second reset with a strap code that disables the port
    arst_n_i <= 1'b0;
    host_select_strap_i <= 3'h4;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("variant", {15'h0, variant_o}, 18'h00004);
    chk("active", {17'h0, indirect_active_o}, 18'h00000);
    $display("test strap done");
    results;
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    results;
  end
endmodule
